/* isr_params.svh */
// constants for the serial register bank of the motion sensor module
// assumes it is included by bare name wherever offsets or timing are needed
`ifndef ISR_PARAMS_SVH
`define ISR_PARAMS_SVH

// serial frame shape
`define ISR_FRAME_BITS      16
`define ISR_CNT_W           4
`define ISR_LAST_BIT        4'hf
`define ISR_WRITE_FLAG_BIT  15

// read word addresses
`define ISR_RA_CTRL         8'h34
`define ISR_RA_UNIT         8'h36
`define ISR_RA_MAKER        8'h37
`define ISR_RA_SERIAL       8'h38
`define ISR_RA_PART         8'h39
`define ISR_RA_HEALTH       8'h3c
`define ISR_RA_MAG_X        8'h48
`define ISR_RA_MAG_Y        8'h4a
`define ISR_RA_MAG_RATIO    8'h4c
`define ISR_RA_MAG_ANGLE    8'h4e
`define ISR_RA_TOP_BIT      8'h5a
`define ISR_RA_HW_BIT       8'h5c
`define ISR_RA_FW_BIT       8'h5e
`define ISR_RA_FW_STATE     8'h60
`define ISR_RA_ALGO_BIT     8'h62
`define ISR_RA_FW_DATA      8'h64
`define ISR_RA_LINK_BIT     8'h66
`define ISR_RA_LINK_STATE   8'h68
`define ISR_RA_PORT_A       8'h6a
`define ISR_RA_PORT_B       8'h6c
`define ISR_RA_XDCR         8'h6e

// byte write addresses, write flag stripped
`define ISR_WA_READY        7'h34
`define ISR_WA_TEST         7'h35
`define ISR_WA_CLOCK        7'h36
`define ISR_WA_RATE         7'h37
`define ISR_WA_FILTER       7'h38
`define ISR_WA_RANGE        7'h39
`define ISR_WA_MAG_CMD      7'h50

// field positions
`define ISR_CTRL_TEST_BIT   10
`define ISR_TEST_BYTE_BIT   2
`define ISR_READY_EN_BIT    2
`define ISR_READY_POL_BIT   1
`define ISR_HEALTH_ST_LSB   10
`define ISR_HEALTH_ST_MSB   15
`define ISR_HEALTH_SUM_BIT  5
`define ISR_HEALTH_OVR_BIT  4
`define ISR_MAG_START_VAL   8'h01

// reset values
`define ISR_CTRL_RESET      16'h0004
`define ISR_HEALTH_RESET    16'h0000
`define ISR_RATE_RESET      4'h1
`define ISR_CLOCK_RESET     1'b1
`define ISR_RANGE_RESET     4'h2
`define ISR_FILTER_RESET    8'h06

// self-test bias window
`define ISR_CLK_MHZ         40
`define ISR_BIAS_TIME_US    10000
`define ISR_BIAS_CYCLES     (`ISR_BIAS_TIME_US * `ISR_CLK_MHZ)

`endif

/* isr_pkg.sv */
// types shared by the serial register bank and its surroundings
// assumes isr_params.svh carries every number
package isr_pkg;

  // results of the compass alignment, supplied by the navigation firmware
  typedef struct packed {
    logic [15:0] offset_x;
    logic [15:0] offset_y;
    logic [15:0] scale_ratio;
    logic [15:0] scale_angle;
  } isr_mag_t;

  // built-in-test words, supplied by the health monitor
  typedef struct packed {
    logic [15:0] top_summary;
    logic [15:0] hw_flags;
    logic [15:0] fw_summary;
    logic [15:0] fw_state;
    logic [15:0] algo_flags;
    logic [15:0] fw_data;
    logic [15:0] link_summary;
    logic [15:0] link_state;
    logic [15:0] port_a;
    logic [15:0] port_b;
    logic [15:0] xdcr_state;
  } isr_bit_t;

  // configuration driven toward the sensing core
  typedef struct packed {
    logic [3:0] sample_rate_code;
    logic       clock_internal;
    logic [3:0] gyro_range;
    logic [7:0] filter_select;
  } isr_cfg_t;

  // self-test sequencer states
  typedef enum logic [2:0] {
    ISR_ST_IDLE   = 3'b001,
    ISR_ST_BIAS   = 3'b010,
    ISR_ST_RECORD = 3'b100
  } isr_st_state_t;

endpackage : isr_pkg

/* isr_sync2.sv */
// two-flop level synchroniser into the system clock domain
// assumes the input is a slow level or toggle from another domain
`timescale 1ns/1ps
module isr_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // first stage feeds only the second
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;

endmodule : isr_sync2

/* isr_spi_link.sv */
// serial shift engine running on the master's serial clock
// assumes clock idles high, data changes on falling, sampled on rising
`timescale 1ns/1ps
`include "isr_params.svh"
module isr_spi_link (
  input  wire logic        sclk_i,
  input  wire logic        rst_i,
  input  wire logic        chip_select_n_i,
  input  wire logic        mosi_i,
  input  wire logic [15:0] tx_word_i,
  output logic      [15:0] rx_word_o,
  output logic             rx_toggle_o,
  output logic             miso_o,
  output logic             miso_oe_o
);

  logic [`ISR_CNT_W-1:0] bit_cnt_ff;
  logic [14:0]           rx_shift_ff;
  logic [15:0]           rx_word_ff;
  logic                  rx_toggle_ff;
  logic [15:0]           tx_shift_ff;
  logic                  miso_ff;
  logic                  oe_ff;
  logic                  loaded_ff;
  wire                   frame_rst = rst_i | chip_select_n_i;

  // receive side; a deselect restarts the frame count
  always_ff @(posedge sclk_i or posedge frame_rst) begin
    if (frame_rst) begin
      bit_cnt_ff  <= '0;
      rx_shift_ff <= '0;
    end else begin
      bit_cnt_ff  <= bit_cnt_ff + 4'h1;
      rx_shift_ff <= {rx_shift_ff[13:0], mosi_i};
    end
  end

  // finished word and its event toggle survive deselect
  always_ff @(posedge sclk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_word_ff   <= '0;
      rx_toggle_ff <= 1'b0;
    end else if (!chip_select_n_i && bit_cnt_ff == `ISR_LAST_BIT) begin
      rx_word_ff   <= {rx_shift_ff, mosi_i};
      rx_toggle_ff <= ~rx_toggle_ff;
    end
  end

  // transmit side; answer word sampled at the first falling edge only
  always_ff @(negedge sclk_i or posedge frame_rst) begin
    if (frame_rst) begin
      tx_shift_ff <= '0;
      miso_ff     <= 1'b0;
      oe_ff       <= 1'b0;
      loaded_ff   <= 1'b0;
    end else begin
      oe_ff     <= 1'b1;
      loaded_ff <= 1'b1;
      if (!loaded_ff) begin
        tx_shift_ff <= {tx_word_i[14:0], 1'b0};
        miso_ff     <= tx_word_i[15];
      end else begin
        tx_shift_ff <= {tx_shift_ff[14:0], 1'b0};
        miso_ff     <= tx_shift_ff[15];
      end
    end
  end

  assign rx_word_o   = rx_word_ff;
  assign rx_toggle_o = rx_toggle_ff;
  assign miso_o      = miso_ff;
  assign miso_oe_o   = oe_ff;

endmodule : isr_spi_link

/* isr_regs.sv */
// serial register bank: system, identity and health reads, byte writes
// assumes the sensing core and health monitor sit on clk_i;
// the serial master owns sclk_i and chip_select_n_i.
//
// Functional notes
// (R1) read-only system words at fixed addresses
// (R2) health bits 15..13: accel z,y,x fail
// (R3) health bits 12..10: rate z,y,x fail
// (R4) health bit 5: overall self-test failure
// (R5) health bit 4: over-range; resets zero
// (R6) writes carry one byte, reads whole word
// (R7) write command: flagged address then data byte
// (R8) 0x35 self-test byte, 0x34 ready byte
// (R9) 0x37 sample rate, 0x36 clock source
// (R10) 0x39 gyro range, 0x38 filter select
// (R11) write to 0x50 starts compass alignment; code starts it only for data byte 0x01
// (R12) word 0x34: test byte high, ready low
// (R13) test bit holds while running, self-clears
// (R14) read of 0x34 returns both bytes
// (R15) master polls 0x34 for test completion
// (R16) test biases sensors, records outcome
// (R17) bit 2 enables ready output, reset 0x0004
// (R18) bit 1 ready polarity, zero active low
// (R19) each exchange is sixteen serial clocks
// (R20) read command is address then zero
// (R21) unused control bits read zero, ignored
`timescale 1ns/1ps
`include "isr_params.svh"
module isr_regs #(
  parameter int          BIAS_CYCLES = `ISR_BIAS_CYCLES,
  parameter logic [15:0] UNIT_INFO   = 16'h0a5a, // arbitrary value
  parameter logic [15:0] MAKER_BUILD = 16'h0c3c, // arbitrary value
  parameter logic [15:0] UNIT_SERIAL = 16'h1234, // arbitrary value
  parameter logic [15:0] PART_IDENT  = 16'h00ab  // arbitrary value
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             sclk_i,
  input  wire logic             chip_select_n_i,
  input  wire logic             mosi_i,
  output logic                  miso_o,
  output logic                  miso_oe_o,
  input  wire logic [5:0]       axis_fail_i,
  input  wire logic             over_range_i,
  input  wire logic             sample_ready_i,
  input  wire isr_pkg::isr_mag_t mag_result_i,
  input  wire isr_pkg::isr_bit_t bit_words_i,
  output logic                  data_ready_o,
  output logic                  sensor_bias_o,
  output logic                  test_busy_o,
  output logic                  mag_align_start_o,
  output isr_pkg::isr_cfg_t     cfg_o
);

  // the bias counter is a plain 32-bit down-counter
  if (BIAS_CYCLES < 1) begin : g_bad_bias
    $error("BIAS_CYCLES must be at least one");
  end

  // control reset held as a vector so single bits can be picked from it
  localparam logic [15:0] CTRL_RESET = `ISR_CTRL_RESET;

  // link domain wires
  logic [15:0] link_rx_word;
  logic        link_rx_toggle;
  logic        rx_toggle_sync;

  // command decode
  logic        rx_seen_ff;
  logic        cmd_valid;
  logic [15:0] cmd;
  logic        cmd_write;
  logic [6:0]  wr_addr;
  logic [7:0]  wr_data;
  logic [7:0]  rd_addr;

  // register state
  logic [15:0] rd_word_ff;
  logic [15:0] nxt_rd_word;
  logic        test_bit_ff;
  logic        ready_en_ff;
  logic        ready_pol_ff;
  logic [15:0] health_ff;
  isr_pkg::isr_cfg_t cfg_ff;
  logic        mag_start_ff;
  logic        data_ready_ff;

  // self-test sequencer
  isr_pkg::isr_st_state_t st_state_ff;
  isr_pkg::isr_st_state_t nxt_st_state;
  logic [31:0] bias_cnt_ff;
  logic        bias_ff;

  // shift engine on the master's clock
  isr_spi_link u_link (
    .sclk_i          (sclk_i),
    .rst_i           (rst_i),
    .chip_select_n_i (chip_select_n_i),
    .mosi_i          (mosi_i),
    .tx_word_i       (rd_word_ff),
    .rx_word_o       (link_rx_word),
    .rx_toggle_o     (link_rx_toggle),
    .miso_o          (miso_o),
    .miso_oe_o       (miso_oe_o)
  ); // sixteen clocks per exchange, see (R19)

  // only the word-complete toggle crosses; the word is held stable behind it
  isr_sync2 #(
    .WIDTH (1)
  ) u_rx_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (link_rx_toggle),
    .sync_o  (rx_toggle_sync)
  );

  // edge of the synchronised toggle marks one finished frame
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_seen_ff <= 1'b0;
    end else begin
      rx_seen_ff <= rx_toggle_sync;
    end
  end

  // the link word is quiet for a whole frame after its toggle moves
  assign cmd_valid = rx_toggle_sync ^ rx_seen_ff;
  assign cmd       = link_rx_word;
  assign cmd_write = cmd[`ISR_WRITE_FLAG_BIT];       // see (R7)
  assign wr_addr   = cmd[14:8];                      // see (R7)
  assign wr_data   = cmd[7:0];                       // one byte only, see (R6)
  assign rd_addr   = cmd[15:8];                      // low byte ignored, see (R20)

  // read multiplexer; unmapped addresses answer zero
  always_comb begin
    unique case (rd_addr)
      `ISR_RA_CTRL: begin // both bytes in one word, see (R12) (R14) (R21)
        nxt_rd_word = 16'h0000;
        nxt_rd_word[`ISR_CTRL_TEST_BIT] = test_bit_ff;
        nxt_rd_word[`ISR_READY_EN_BIT]  = ready_en_ff;
        nxt_rd_word[`ISR_READY_POL_BIT] = ready_pol_ff;
      end
      `ISR_RA_UNIT:       nxt_rd_word = UNIT_INFO;   // see (R1)
      `ISR_RA_MAKER:      nxt_rd_word = MAKER_BUILD;
      `ISR_RA_SERIAL:     nxt_rd_word = UNIT_SERIAL;
      `ISR_RA_PART:       nxt_rd_word = PART_IDENT;
      `ISR_RA_HEALTH:     nxt_rd_word = health_ff;   // see (R1)
      `ISR_RA_MAG_X:      nxt_rd_word = mag_result_i.offset_x;
      `ISR_RA_MAG_Y:      nxt_rd_word = mag_result_i.offset_y;
      `ISR_RA_MAG_RATIO:  nxt_rd_word = mag_result_i.scale_ratio;
      `ISR_RA_MAG_ANGLE:  nxt_rd_word = mag_result_i.scale_angle;
      `ISR_RA_TOP_BIT:    nxt_rd_word = bit_words_i.top_summary;
      `ISR_RA_HW_BIT:     nxt_rd_word = bit_words_i.hw_flags;
      `ISR_RA_FW_BIT:     nxt_rd_word = bit_words_i.fw_summary;
      `ISR_RA_FW_STATE:   nxt_rd_word = bit_words_i.fw_state;
      `ISR_RA_ALGO_BIT:   nxt_rd_word = bit_words_i.algo_flags;
      `ISR_RA_FW_DATA:    nxt_rd_word = bit_words_i.fw_data;
      `ISR_RA_LINK_BIT:   nxt_rd_word = bit_words_i.link_summary;
      `ISR_RA_LINK_STATE: nxt_rd_word = bit_words_i.link_state;
      `ISR_RA_PORT_A:     nxt_rd_word = bit_words_i.port_a;
      `ISR_RA_PORT_B:     nxt_rd_word = bit_words_i.port_b;
      `ISR_RA_XDCR:       nxt_rd_word = bit_words_i.xdcr_state; // see (R1)
      default:            nxt_rd_word = 16'h0000;
    endcase
  end

  // answer word captured once per read command, shifted out next frame;
  // a write leaves the previous answer in place
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_word_ff <= 16'h0000;
    end else if (cmd_valid && !cmd_write) begin
      rd_word_ff <= nxt_rd_word; // see (R6)
    end
  end

  // data-ready byte; only enable and polarity are stored
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ready_en_ff  <= CTRL_RESET[`ISR_READY_EN_BIT];  // see (R17)
      ready_pol_ff <= CTRL_RESET[`ISR_READY_POL_BIT]; // see (R18)
    end else if (cmd_valid && cmd_write && wr_addr == `ISR_WA_READY) begin
      ready_en_ff  <= wr_data[`ISR_READY_EN_BIT];  // see (R8) (R17) (R21)
      ready_pol_ff <= wr_data[`ISR_READY_POL_BIT]; // see (R18)
    end
  end

  // configuration bytes toward the sensing core
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_ff.sample_rate_code <= `ISR_RATE_RESET;
      cfg_ff.clock_internal   <= `ISR_CLOCK_RESET;
      cfg_ff.gyro_range       <= `ISR_RANGE_RESET;
      cfg_ff.filter_select    <= `ISR_FILTER_RESET;
    end else if (cmd_valid && cmd_write) begin
      unique case (wr_addr)
        `ISR_WA_RATE:   cfg_ff.sample_rate_code <= wr_data[3:0]; // see (R9)
        `ISR_WA_CLOCK:  cfg_ff.clock_internal   <= wr_data[0];   // see (R9)
        `ISR_WA_RANGE:  cfg_ff.gyro_range       <= wr_data[3:0]; // see (R10)
        `ISR_WA_FILTER: cfg_ff.filter_select    <= wr_data;      // see (R10)
        default: begin
        end
      endcase
    end
  end

  // one-cycle alignment start; other values of the command byte are ignored
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mag_start_ff <= 1'b0;
    end else begin
      mag_start_ff <= cmd_valid && cmd_write && wr_addr == `ISR_WA_MAG_CMD
                      && wr_data == `ISR_MAG_START_VAL; // see (R11)
    end
  end

  // test bit: master sets it, the sequencer clears it on completion;
  // a set in the completion cycle wins so the request is not lost
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      test_bit_ff <= CTRL_RESET[`ISR_CTRL_TEST_BIT];
    end else if (cmd_valid && cmd_write && wr_addr == `ISR_WA_TEST
                 && wr_data[`ISR_TEST_BYTE_BIT]) begin
      test_bit_ff <= 1'b1; // see (R8) (R13)
    end else if (st_state_ff == isr_pkg::ISR_ST_RECORD) begin
      test_bit_ff <= 1'b0; // cleared when done, see (R13) (R15)
    end
  end

  // sequencer next state
  always_comb begin
    nxt_st_state = st_state_ff;
    unique case (st_state_ff)
      isr_pkg::ISR_ST_IDLE: begin
        if (test_bit_ff) begin
          nxt_st_state = isr_pkg::ISR_ST_BIAS; // see (R16)
        end
      end
      isr_pkg::ISR_ST_BIAS: begin
        if (bias_cnt_ff == 32'h0000_0001) begin
          nxt_st_state = isr_pkg::ISR_ST_RECORD;
        end
      end
      isr_pkg::ISR_ST_RECORD: begin
        nxt_st_state = isr_pkg::ISR_ST_IDLE;
      end
      default: begin
        nxt_st_state = isr_pkg::ISR_ST_IDLE;
      end
    endcase
  end

  // sequencer state, bias window and bias drive
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_state_ff <= isr_pkg::ISR_ST_IDLE;
      bias_cnt_ff <= 32'h0000_0000;
      bias_ff     <= 1'b0;
    end else begin
      st_state_ff <= nxt_st_state;
      if (st_state_ff == isr_pkg::ISR_ST_IDLE && test_bit_ff) begin
        bias_cnt_ff <= 32'(BIAS_CYCLES);
        bias_ff     <= 1'b1; // temporary bias applied, see (R16)
      end else if (st_state_ff == isr_pkg::ISR_ST_BIAS) begin
        bias_cnt_ff <= bias_cnt_ff - 32'h0000_0001;
        bias_ff     <= (bias_cnt_ff != 32'h0000_0001);
      end else begin
        bias_ff     <= 1'b0;
      end
    end
  end

  // health word: axis results and summary at test end, sticky over-range;
  // reading the word clears over-range unless the sensor still reports it
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      health_ff <= `ISR_HEALTH_RESET; // see (R5)
    end else begin
      if (st_state_ff == isr_pkg::ISR_ST_RECORD) begin
        health_ff[`ISR_HEALTH_ST_MSB:`ISR_HEALTH_ST_LSB] <= axis_fail_i; // see (R2) (R3)
        health_ff[`ISR_HEALTH_SUM_BIT] <= |axis_fail_i;                 // see (R4)
      end
      if (over_range_i) begin
        health_ff[`ISR_HEALTH_OVR_BIT] <= 1'b1; // set wins, see (R5)
      end else if (cmd_valid && !cmd_write && rd_addr == `ISR_RA_HEALTH) begin
        health_ff[`ISR_HEALTH_OVR_BIT] <= 1'b0;
      end
    end
  end

  // data-ready pin: one cycle at the active level per sample, idle otherwise
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      data_ready_ff <= ~CTRL_RESET[`ISR_READY_POL_BIT];
    end else if (ready_en_ff && sample_ready_i) begin
      data_ready_ff <= ready_pol_ff;  // see (R17) (R18)
    end else begin
      data_ready_ff <= ~ready_pol_ff; // disabled holds idle level
    end
  end

  assign data_ready_o      = data_ready_ff;
  assign sensor_bias_o     = bias_ff;
  assign test_busy_o       = test_bit_ff;
  assign mag_align_start_o = mag_start_ff;
  assign cfg_o             = cfg_ff;

endmodule : isr_regs

/* isr_regs_assertions.sv */
// checker for the serial register bank, bound onto isr_regs
// assumes one system clock domain, reset active high and asynchronous
`timescale 1ns/1ps
module isr_regs_checker #(
  parameter int BIAS_CYCLES = 8
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              chip_select_n_i,
  input  wire logic              sample_ready_i,
  input  wire logic              miso_oe_o,
  input  wire logic              data_ready_o,
  input  wire logic              sensor_bias_o,
  input  wire logic              test_busy_o,
  input  wire logic              mag_align_start_o,
  input  wire isr_pkg::isr_cfg_t cfg_o
);
  logic [31:0] bias_cnt_ff;
  logic [3:0]  idle_cnt_ff;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // bias window length and clocks since deselect; the deselect count saturates so it never wraps
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bias_cnt_ff <= 32'h0;
      idle_cnt_ff <= 4'h0;
    end else begin
      bias_cnt_ff <= sensor_bias_o ? bias_cnt_ff + 32'h1 : 32'h0;
      idle_cnt_ff <= !chip_select_n_i ? 4'h0 : idle_cnt_ff + {3'h0, idle_cnt_ff != 4'hf};
    end
  end

  property p_bias_busy;
    sensor_bias_o |-> test_busy_o;
  endproperty
  a_bias_busy: assert property (p_bias_busy)
    else $error("bias without running test");
  property p_bias_len;
    $fell(sensor_bias_o) |-> bias_cnt_ff == BIAS_CYCLES;
  endproperty
  a_bias_len: assert property (p_bias_len)
    else $error("bias window length wrong");
  property p_busy_start;
    $rose(test_busy_o) |-> idle_cnt_ff inside {[1:10]} ##[1:2] sensor_bias_o;
  endproperty
  a_busy_start: assert property (p_busy_start)
    else $error("test start not tied to a frame");
  property p_busy_end;
    $fell(sensor_bias_o) |-> ##[1:2] !test_busy_o;
  endproperty
  a_busy_end: assert property (p_busy_end)
    else $error("test bit did not clear");
  property p_cfg_cause;
    $changed(cfg_o) |-> idle_cnt_ff inside {[1:10]};
  endproperty
  a_cfg_cause: assert property (p_cfg_cause)
    else $error("config changed without a frame");
  property p_mag_pulse;
    mag_align_start_o |-> idle_cnt_ff inside {[1:10]} ##1 !mag_align_start_o;
  endproperty
  a_mag_pulse: assert property (p_mag_pulse)
    else $error("alignment start pulse wrong");
  property p_drdy_back;
    $changed(data_ready_o) && $past(sample_ready_i) && !sample_ready_i
      |=> $changed(data_ready_o);
  endproperty
  a_drdy_back: assert property (p_drdy_back)
    else $error("data ready pulse not one clock");
  property p_oe_off;
    chip_select_n_i |-> !miso_oe_o;
  endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("output driven while deselected");
  property p_oe_on;
    $rose(miso_oe_o) |-> !chip_select_n_i;
  endproperty
  a_oe_on: assert property (p_oe_on)
    else $error("output enabled outside frame");
endmodule : isr_regs_checker

bind isr_regs isr_regs_checker #(.BIAS_CYCLES(BIAS_CYCLES)) isr_regs_checker_inst (
  .clk_i(clk_i), .rst_i(rst_i), .chip_select_n_i(chip_select_n_i),
  .sample_ready_i(sample_ready_i), .miso_oe_o(miso_oe_o), .data_ready_o(data_ready_o),
  .sensor_bias_o(sensor_bias_o), .test_busy_o(test_busy_o),
  .mag_align_start_o(mag_align_start_o), .cfg_o(cfg_o));

/* isr_spi_master.sv */
// serial host model: sixteen-clock frames, clock idles high
// assumes the device samples on rising and shifts on falling edges
`timescale 1ns/1ps
module isr_spi_master (
  output logic      sclk_o,
  output logic      chip_select_n_o,
  output logic      mosi_o,
  input  wire logic miso_i
);
  // clock parked high between frames, never free running
  initial begin
    sclk_o = 1'b1;
    chip_select_n_o = 1'b1;
    mosi_o = 1'b0;
  end

  // one exchange, msb first; answer taken at each rising edge
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    chip_select_n_o = 1'b0;
    #5;
    for (int i = 15; i >= 0; i--) begin
      sclk_o = 1'b0;
      mosi_o = tx[i];
      #6;
      sclk_o = 1'b1;
      rx[i] = miso_i;
      #6;
    end
    chip_select_n_o = 1'b1;
    mosi_o = ~tx[0]; // released line must not keep the last bit
    #300; // answer word needs time to settle
  endtask : xfer
endmodule : isr_spi_master

/* test_isr_regs.sv */
// self-checking bench for the serial register bank
// assumes isr_spi_master stands in for the serial host
`timescale 1ns/1ps
module test_isr_regs;
  localparam int BIAS = 64;
  logic              clk_i, rst_i, sample_ready_i, over_range_i;
  logic              sclk_i, chip_select_n_i, mosi_i, miso_w;
  logic              miso_o, miso_oe_o, data_ready_o, sensor_bias_o;
  logic              test_busy_o, mag_align_start_o, c;
  logic [5:0]        axis_fail_i;
  logic [5:0]        fl [2];
  logic [3:0]        r, g;
  logic [7:0]        f;
  logic [15:0]       d;
  isr_pkg::isr_mag_t mag_result_i;
  isr_pkg::isr_bit_t bit_words_i;
  isr_pkg::isr_cfg_t cfg_o;
  int                miscompares, comparisons, mag_cnt, n;

  // identity words are arbitrary values
  isr_regs #(.BIAS_CYCLES(BIAS), .UNIT_INFO(16'h1111), .MAKER_BUILD(16'h2222),
    .UNIT_SERIAL(16'h3333), .PART_IDENT(16'h4444)) isr_regs_inst (
    .clk_i(clk_i), .rst_i(rst_i), .sclk_i(sclk_i), .chip_select_n_i(chip_select_n_i),
    .mosi_i(mosi_i), .miso_o(miso_o), .miso_oe_o(miso_oe_o), .axis_fail_i(axis_fail_i),
    .over_range_i(over_range_i), .sample_ready_i(sample_ready_i),
    .mag_result_i(mag_result_i), .bit_words_i(bit_words_i), .data_ready_o(data_ready_o),
    .sensor_bias_o(sensor_bias_o), .test_busy_o(test_busy_o),
    .mag_align_start_o(mag_align_start_o), .cfg_o(cfg_o));
  isr_spi_master master_inst (.sclk_o(sclk_i), .chip_select_n_o(chip_select_n_i),
    .mosi_o(mosi_i), .miso_i(miso_w));

  // undriven data line toggles so nothing stale can pass
  assign miso_w = miso_oe_o ? miso_o : clk_i;
  // system clock, 25 ns
  always #12.5 clk_i = ~clk_i;
  // alignment start pulses seen
  always @(posedge clk_i) if (mag_align_start_o === 1'b1) mag_cnt++;

  function automatic logic [15:0] health(input logic [5:0] a, input logic ov);
    return {a, 4'h0, |a, ov, 4'h0};
  endfunction : health

  task automatic wrap_up;
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up

  task automatic check(input logic [16:0] got, input logic [16:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    logic [15:0] x;
    master_inst.xfer({a, 8'h00}, x);
    master_inst.xfer(16'h0000, v);
  endtask : rd

  task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] v;
    rd(a, v);
    check({1'b0, v}, {1'b0, e});
  endtask : rdchk

  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    logic [15:0] x;
    master_inst.xfer({1'b1, a, v}, x);
  endtask : wr

  // one sample pulse; counts clocks at the active level
  task automatic pulse(input logic idle, input logic act, input int cnt);
    int k;
    k = 0;
    @(negedge clk_i) sample_ready_i = 1'b1;
    // active level stands from the first of these edges for one clock
    repeat (3) @(negedge clk_i) begin
      sample_ready_i = 1'b0;
      k += int'(data_ready_o === act);
    end
    check(17'(k), 17'(cnt));
    check({16'h0, data_ready_o}, {16'h0, idle});
  endtask : pulse

  // hang guard
  initial begin
    #1ms;
    miscompares++;
    wrap_up();
  end

  // main sequence
  initial begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    {sample_ready_i, over_range_i, axis_fail_i, mag_cnt} = '0;
    n = $urandom(32'hef7d);
    for (int i = 0; i < 4; i++) mag_result_i[16*i +: 16] = 16'($urandom);
    for (int i = 0; i < 11; i++) bit_words_i[16*i +: 16] = 16'($urandom);
    repeat (6) @(posedge clk_i);
    @(negedge clk_i) rst_i = 1'b0;
    repeat (3) @(negedge clk_i);
    check(cfg_o, {4'h1, 1'b1, 4'h2, 8'h06});
    check({15'h0, data_ready_o, test_busy_o}, 17'h2);
    rdchk(8'h34, 16'h0004);
    rdchk(8'h3c, 16'h0000);
    $display("test reset done");
    for (int i = 0; i < 4; i++) rdchk(8'(8'h36 + i), 16'(16'h1111 * (i + 1)));
    for (int i = 0; i < 4; i++) rdchk(8'(8'h48 + 2 * i), mag_result_i[63-16*i -: 16]);
    for (int i = 0; i < 11; i++) rdchk(8'(8'h5a + 2 * i), bit_words_i[175-16*i -: 16]);
    rdchk(8'h02, 16'h0000);
    $display("test read map done");
    for (int k = 0; k < 4; k++) begin
      {r, g, f, c} = 17'($urandom);
      wr(7'h37, {4'h0, r});
      wr(7'h36, {7'h0, c});
      wr(7'h39, {4'h0, g});
      wr(7'h38, f);
      wr(7'h3a, 8'hff);
      check(cfg_o, {r, c, g, f});
    end
    $display("test config done");
    wr(7'h34, 8'h06);
    rdchk(8'h34, 16'h0006);
    pulse(1'b0, 1'b1, 1);
    wr(7'h34, 8'hf8);
    rdchk(8'h34, 16'h0000);
    pulse(1'b1, 1'b0, 0);
    wr(7'h34, 8'h04);
    pulse(1'b1, 1'b0, 1);
    $display("test data ready done");
    wr(7'h50, 8'h01);
    wr(7'h50, 8'h02);
    wr(7'h50, 8'h01);
    check(17'(mag_cnt), 17'h2);
    $display("test alignment done");
    fl[0] = 6'h00;
    fl[1] = 6'($urandom) | 6'h21;
    for (int j = 0; j < 2; j++) begin
      @(negedge clk_i) axis_fail_i = fl[j];
      wr(7'h35, 8'h04);
      check({15'h0, sensor_bias_o, test_busy_o}, 17'h3);
      rd(8'h34, d);
      check({1'b0, d}, 17'h0404);
      for (n = 0; n < 20 && d !== 16'h0004; n++) rd(8'h34, d);
      check({1'b0, d}, 17'h0004);
      rdchk(8'h3c, health(fl[j], 1'b0));
    end
    $display("test self-test done");
    @(negedge clk_i) over_range_i = 1'b1;
    @(negedge clk_i) over_range_i = 1'b0;
    rdchk(8'h3c, health(fl[1], 1'b1));
    rdchk(8'h3c, health(fl[1], 1'b0));
    $display("test over-range done");
    wrap_up();
  end
endmodule : test_isr_regs
